// file: rlom_line_model.sv
// Line-side model: emits received frames with their B2 error counts.
// Assumes the bench calls send_frame from its main process only.
module rlom_line_model (
    input wire logic clk,
    output logic frame_strobe,
    output logic [4:0] b2_err_bits
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        frame_strobe = 1'b0;
        b2_err_bits = 5'h15;
    end
    // Count is qualified by the strobe only, so garble it in between
    task automatic send_frame(input logic [4:0] n);
        @(posedge clk);
        frame_strobe <= 1'b1;
        b2_err_bits <= n;
        @(posedge clk);
        frame_strobe <= 1'b0;
        b2_err_bits <= ~n;
    endtask : send_frame
endmodule : rlom_line_model

// file: rlom_monitor.sv
// Receive line overhead monitor: alarm state bits, read-to-clear interrupt
// latches with enables, and a saturating 20-bit B2 error count snapshot.
// Assumes per-frame overhead results arrive synchronous to ref_clk, with
// frame_strobe high for one cycle per received frame.
// How it works
// - Per-frame mode counts one per errored frame
// - Per-bit mode adds erroneous B2 bit count
// - Alarm state set by AIS, loss, frame loss
// - Remote defect state shown in bit zero
// - Far-end error flag enabled drives interrupt
// - B2 error flag enabled drives interrupt
// - Alarm flag enabled drives interrupt low
// - Remote defect change enabled drives interrupt
// - Far-end error latched, cleared on read
// - B2 error latched, cleared on read
// - Alarm detection latched, cleared on read
// - Remote defect change latched, cleared on read
// - Write triggers delayed snapshot and restart
// - Snapshot twenty bits, low and mid bytes
// - Third register holds bits nineteen to sixteen
module rlom_monitor
    import rlom_pkg::*;
#(
    parameter int ERR_BITS_W = 5
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic frame_strobe,
    input wire logic [ERR_BITS_W-1:0] b2_err_bits,
    input wire logic far_end_err,
    input wire logic line_ais_detected,
    input wire logic signal_lost,
    input wire logic frame_lost,
    input wire logic remote_defect_detected,
    output logic irq_out_n
);
    logic rst_meta_n;
    logic rst_n;
    rlom_state_t st;
    rlom_state_t next_st;

    // Release reset through two stages so the release is glitch free
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    function automatic logic [SNAP_W-1:0] sat_add(
        input logic [SNAP_W-1:0] a,
        input logic [ERR_BITS_W-1:0] b
    );
        logic [SNAP_W:0] sum;
        sum = {1'b0, a} + (SNAP_W+1)'(b);
        sat_add = sum[SNAP_W] ? SNAP_MAX : sum[SNAP_W-1:0];
    endfunction : sat_add

    function automatic logic snap_trigger(input logic [ADDR_W-1:0] a);
        snap_trigger = (a == OFS_MASTER) ||
            (a >= OFS_B2_LOW && a <= OFS_FE_HIGH);
    endfunction : snap_trigger

    logic bus_req;
    // Writes land on the ack edge, while the request still stands
    logic wr_done;
    logic alarm_now;
    logic [ERR_BITS_W-1:0] add_amt;
    logic [3:0] events;
    logic [3:0] flags_set;

    always_comb begin
        next_st = st;
        bus_req = wb_cyc_i && wb_stb_i && !st.bus.ack;
        wr_done = wb_cyc_i && wb_stb_i && wb_we_i && st.bus.ack;
        alarm_now = line_ais_detected || signal_lost || frame_lost;
        // One count per errored frame, or every errored bit
        add_amt = '0;
        if (frame_strobe && b2_err_bits != '0) begin
            if (st.b2_per_bit_count_sel) begin
                add_amt = b2_err_bits;
            end else begin
                add_amt = ERR_BITS_W'(1);
            end
        end
        events = '0;
        events[BIT_FE_FLAG] = far_end_err;
        events[BIT_B2_FLAG] = frame_strobe && b2_err_bits != '0;
        events[BIT_LA_FLAG] = alarm_now && !st.line_alarm_state;
        events[BIT_RD_FLAG] = remote_defect_detected !=
            st.remote_defect_state;
        next_st.line_alarm_state = alarm_now;
        next_st.remote_defect_state = remote_defect_detected;

        next_st.bus.ack = bus_req;
        next_st.bus.dat = RST_BYTE;
        flags_set = st.irq_flag;
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                OFS_CTRL_STATUS: next_st.bus.dat = {
                    st.b2_per_bit_count_sel, 5'h00,
                    st.line_alarm_state, st.remote_defect_state};
                OFS_IRQ_EN_STATUS: begin
                    next_st.bus.dat = {st.irq_en, st.irq_flag};
                    flags_set = '0;
                end
                OFS_B2_LOW: next_st.bus.dat = st.b2_err_snapshot[7:0];
                OFS_B2_MID: next_st.bus.dat = st.b2_err_snapshot[15:8];
                OFS_B2_HIGH: next_st.bus.dat = {RST_NIBBLE,
                    st.b2_err_snapshot[19:16]};
                default: next_st.bus.dat = RST_BYTE;
            endcase
        end
        // Set wins over the read clear
        next_st.irq_flag = flags_set | events;
        if (wr_done && wb_sel_i) begin
            if (wb_adr_i == OFS_CTRL_STATUS) begin
                next_st.b2_per_bit_count_sel = wb_dat_i[BIT_PER_BIT_SEL];
            end
            if (wb_adr_i == OFS_IRQ_EN_STATUS) begin
                next_st.irq_en = wb_dat_i[BIT_FE_IRQ_EN:BIT_RD_IRQ_EN];
            end
        end

        next_st.b2_acc = sat_add(st.b2_acc, add_amt);
        case (st.snap_state)
            RLOM_SNAP_IDLE: begin
                if (wr_done && snap_trigger(wb_adr_i)) begin
                    next_st.snap_state = RLOM_SNAP_WAIT;
                    next_st.snap_dly = DLY_W'(SNAP_DELAY_CYC - 1);
                end
            end
            RLOM_SNAP_WAIT: begin
                if (st.snap_dly == '0) begin
                    // Errors of this frame go to the new round
                    next_st.b2_err_snapshot = st.b2_acc;
                    next_st.b2_acc = sat_add('0, add_amt);
                    next_st.snap_state = RLOM_SNAP_IDLE;
                end else begin
                    next_st.snap_dly = st.snap_dly - DLY_W'(1);
                end
            end
            default: next_st.snap_state = RLOM_SNAP_IDLE;
        endcase

        // Enables align with flags: en[3]=FE..en[0]=RD
        next_st.irq_out_n = ~|(next_st.irq_flag & st.irq_en);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{b2_per_bit_count_sel: 1'b0, irq_en: 4'h0,
                irq_flag: 4'h0, line_alarm_state: 1'b0,
                remote_defect_state: 1'b0, b2_acc: 20'h00000,
                b2_err_snapshot: 20'h00000, snap_state: RLOM_SNAP_IDLE,
                snap_dly: 8'h00, bus: '{dat: 8'h00, ack: 1'b0},
                irq_out_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.bus.dat;
    assign wb_ack_o = st.bus.ack;
    assign irq_out_n = st.irq_out_n;

    snap_delay_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(st.snap_state == RLOM_SNAP_WAIT)
        |-> ##[1:10] st.snap_state == RLOM_SNAP_IDLE)
        else $error("snapshot not taken in time");

    snap_restart_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.snap_state == RLOM_SNAP_WAIT && st.snap_dly == '0
        |=> st.b2_err_snapshot == $past(st.b2_acc))
        else $error("snapshot does not hold count");

    b2_frame_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.snap_state == RLOM_SNAP_IDLE && !st.b2_per_bit_count_sel &&
        frame_strobe && b2_err_bits != '0 && st.b2_acc != SNAP_MAX
        |=> st.b2_acc == $past(st.b2_acc) + 20'h00001)
        else $error("per-frame count wrong");

    b2_bits_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.snap_state == RLOM_SNAP_IDLE && st.b2_per_bit_count_sel &&
        frame_strobe && st.b2_acc < 20'hfff00
        |=> st.b2_acc == $past(st.b2_acc) + SNAP_W'($past(b2_err_bits)))
        else $error("per-bit count wrong");

    b2_sat_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.b2_acc == SNAP_MAX && st.snap_state == RLOM_SNAP_IDLE
        |=> st.b2_acc == SNAP_MAX)
        else $error("counter wrapped");

    alarm_state_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (signal_lost || frame_lost)
        |=> st.line_alarm_state)
        else $error("alarm state missing");

    rd_flag_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        remote_defect_detected != st.remote_defect_state
        |=> st.irq_flag[BIT_RD_FLAG])
        else $error("remote defect change not latched");

    fe_flag_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        far_end_err
        |=> st.irq_flag[BIT_FE_FLAG])
        else $error("far-end error not latched");

    irq_level_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        |(st.irq_flag & st.irq_en) ##1 |(st.irq_flag & $past(st.irq_en))
        |-> !irq_out_n)
        else $error("interrupt not asserted");

    read_clear_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i && wb_adr_i == OFS_IRQ_EN_STATUS && !far_end_err
        |=> !st.irq_flag[BIT_FE_FLAG])
        else $error("flag not cleared by read");

    b2_flag_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        frame_strobe && b2_err_bits != '0
        |=> st.irq_flag[BIT_B2_FLAG])
        else $error("b2 flag not latched");

    ack_pulse_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wb_ack_o
        |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    ack_answer_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o)
        else $error("request not answered");

    idle_data_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !wb_ack_o
        |-> wb_dat_o == RST_BYTE)
        else $error("read data outside answer");

    rd_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i && wb_adr_i == OFS_CTRL_STATUS
        |=> wb_dat_o[0] == $past(st.remote_defect_state))
        else $error("remote defect bit misread");

    la_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i && wb_adr_i == OFS_CTRL_STATUS
        |=> wb_dat_o[1] == $past(st.line_alarm_state))
        else $error("alarm bit misread");

    high_nibble_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i && wb_adr_i == OFS_B2_HIGH
        |=> wb_dat_o == {4'h0, $past(st.b2_err_snapshot[19:16])})
        else $error("high count byte wrong");

    low_byte_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i && wb_adr_i == OFS_B2_LOW
        |=> wb_dat_o == $past(st.b2_err_snapshot[7:0]))
        else $error("low count byte wrong");

    mid_byte_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i && wb_adr_i == OFS_B2_MID
        |=> wb_dat_o == $past(st.b2_err_snapshot[15:8]))
        else $error("mid count byte wrong");

    la_flag_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        line_ais_detected && !st.line_alarm_state
        |=> st.irq_flag[BIT_LA_FLAG])
        else $error("alarm detection not latched");

    ais_state_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        line_ais_detected
        |=> st.line_alarm_state)
        else $error("alarm state not set");

    alarm_clear_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !(line_ais_detected || signal_lost || frame_lost)
        |=> !st.line_alarm_state)
        else $error("alarm state stuck");

    rd_state_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1
        |=> st.remote_defect_state == $past(remote_defect_detected))
        else $error("remote defect state wrong");

    irq_match_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1
        |=> irq_out_n == !(|(st.irq_flag & $past(st.irq_en))))
        else $error("interrupt level wrong");

    b2_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !st.irq_flag[BIT_B2_FLAG] && !frame_strobe
        |=> !st.irq_flag[BIT_B2_FLAG])
        else $error("b2 flag set without error");

    fe_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !st.irq_flag[BIT_FE_FLAG] && !far_end_err
        |=> !st.irq_flag[BIT_FE_FLAG])
        else $error("far-end flag set without error");

    rd_sticky_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.irq_flag[BIT_RD_FLAG] && !(bus_req && wb_adr_i == OFS_IRQ_EN_STATUS)
        |=> st.irq_flag[BIT_RD_FLAG])
        else $error("remote defect flag lost");

    snap_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.snap_state == RLOM_SNAP_IDLE
        |=> $stable(st.b2_err_snapshot))
        else $error("snapshot changed while idle");

    acc_restart_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.snap_state == RLOM_SNAP_WAIT && st.snap_dly == '0 && !frame_strobe
        |=> st.b2_acc == '0)
        else $error("count not restarted");

    frame_step_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !st.b2_per_bit_count_sel && st.snap_state == RLOM_SNAP_IDLE
        |=> st.b2_acc - $past(st.b2_acc) <= 20'h00001)
        else $error("per-frame step too large");

    no_frame_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.snap_state == RLOM_SNAP_IDLE && !frame_strobe
        |=> $stable(st.b2_acc))
        else $error("count moved without frame");

    snap_c: cover property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.snap_state == RLOM_SNAP_WAIT ##[1:12] st.b2_err_snapshot != '0);

    irq_c: cover property (
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(irq_out_n));

    per_bit_c: cover property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.b2_per_bit_count_sel && frame_strobe && b2_err_bits > 5'd1);

    rd_change_c: cover property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.irq_flag[BIT_RD_FLAG] && st.irq_en[BIT_RD_FLAG]);

    masked_c: cover property (
        @(posedge ref_clk) disable iff (!rst_n)
        st.irq_flag[BIT_B2_FLAG] && !st.irq_en[BIT_B2_FLAG] && irq_out_n);
endmodule : rlom_monitor

// file: rlom_pkg.sv
// Package for the receive line overhead monitor: register map, fields,
// reset values, timing counts and the state record.
// Assumes a 10 MHz reference clock and an 8-bit register space on Wishbone.
package rlom_pkg;
    localparam int REF_CLK_HZ = 10000000;
    localparam int SNAP_DELAY_NS = 1000;
    // Longest time rounds down, never below one cycle
    localparam int SNAP_DELAY_CYC_RAW = SNAP_DELAY_NS / (1000000000 / REF_CLK_HZ);
    localparam int SNAP_DELAY_CYC = SNAP_DELAY_CYC_RAW < 1 ? 1 : SNAP_DELAY_CYC_RAW;

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MASTER = 8'h00;
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN_STATUS = 8'h19;
    localparam logic [7:0] OFS_B2_LOW = 8'h1a;
    localparam logic [7:0] OFS_B2_MID = 8'h1b;
    localparam logic [7:0] OFS_B2_HIGH = 8'h1c;
    localparam logic [7:0] OFS_FE_LOW = 8'h1d;
    localparam logic [7:0] OFS_FE_HIGH = 8'h1f;

    localparam int BIT_PER_BIT_SEL = 7;
    localparam int BIT_LINE_ALARM_STATE = 1;
    localparam int BIT_REMOTE_DEFECT_STATE = 0;
    localparam int BIT_FE_IRQ_EN = 7;
    localparam int BIT_B2_IRQ_EN = 6;
    localparam int BIT_LA_IRQ_EN = 5;
    localparam int BIT_RD_IRQ_EN = 4;
    localparam int BIT_FE_FLAG = 3;
    localparam int BIT_B2_FLAG = 2;
    localparam int BIT_LA_FLAG = 1;
    localparam int BIT_RD_FLAG = 0;

    localparam int SNAP_W = 20;
    localparam logic [SNAP_W-1:0] SNAP_MAX = 20'hfffff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam int DLY_W = 8;

    typedef enum logic [1:0] {
        RLOM_SNAP_IDLE = 2'b00,
        RLOM_SNAP_WAIT = 2'b01
    } rlom_snap_state_t;

    typedef struct packed {
        logic [7:0] dat;
        logic ack;
    } rlom_bus_out_t;

    typedef struct packed {
        logic b2_per_bit_count_sel;
        logic [3:0] irq_en;
        logic [3:0] irq_flag;
        logic line_alarm_state;
        logic remote_defect_state;
        logic [SNAP_W-1:0] b2_acc;
        logic [SNAP_W-1:0] b2_err_snapshot;
        rlom_snap_state_t snap_state;
        logic [DLY_W-1:0] snap_dly;
        rlom_bus_out_t bus;
        logic irq_out_n;
    } rlom_state_t;
endpackage : rlom_pkg

// file: tb_top.sv
// Self-checking bench for the line overhead monitor.
// Assumes the package constants and the line model beside it.
module tb_top;
    import rlom_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, resetn, cyc, stb, we, sel, fe, ais, loss_sig, loss_frm;
    logic rdi;
    logic ack, irq_n, fs;
    logic [7:0] adr, wdat, rdat, dat_o;
    logic [4:0] eb;
    logic [19:0] total;
    int failures, check_count, seed;

    rlom_monitor i_rlom_monitor (.ref_clk(ref_clk), .resetn(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .frame_strobe(fs), .b2_err_bits(eb), .far_end_err(fe),
        .line_ais_detected(ais), .signal_lost(loss_sig),
        .frame_lost(loss_frm),
        .remote_defect_detected(rdi), .irq_out_n(irq_n));
    rlom_line_model i_rlom_line_model (.clk(ref_clk), .frame_strobe(fs),
        .b2_err_bits(eb));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic print_verdict;
        $display("Checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [19:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        if (n >= 20) failures++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic rd_chk(input string nm, input logic [7:0] a, e);
        bus(1'b0, a, 8'h00);
        chk(nm, 20'(rdat), 20'(e));
    endtask : rd_chk

    function automatic logic [19:0] exp_err(input logic pb,
                                            input logic [4:0] n);
        return pb ? 20'(n) : 20'(n != 5'h00);
    endfunction : exp_err

    // First two frames are the corner counts, the rest random
    task automatic frames(input logic pb, input int cnt);
        logic [4:0] n;
        total = 20'h0;
        for (int i = 0; i < cnt; i++) begin
            n = (i == 0) ? 5'd24 : (i == 1) ? 5'd0 :
                5'($unsigned($random(seed)) % 25);
            i_rlom_line_model.send_frame(n);
            total += exp_err(pb, n);
        end
    endtask : frames

    task automatic snap_chk(input logic [7:0] a, input logic [19:0] e);
        bus(1'b1, a, 8'h00);
        repeat (SNAP_DELAY_CYC + 3) @(posedge ref_clk);
        rd_chk("count_low", OFS_B2_LOW, e[7:0]);
        rd_chk("count_mid", OFS_B2_MID, e[15:8]);
        rd_chk("count_high", OFS_B2_HIGH, {4'h0, e[19:16]});
    endtask : snap_chk

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        print_verdict();
    end

    initial begin
        {cyc, stb, we, fe, ais, loss_sig, loss_frm, rdi} = 8'h00;
        sel = 1'b1;
        adr = 8'h00;
        wdat = 8'h00;
        seed = 32'hb5a34fd2;
        resetn = 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk("ctrl_reset", OFS_CTRL_STATUS, 8'h00);
        rd_chk("irq_reset", OFS_IRQ_EN_STATUS, 8'h00);
        rd_chk("unmapped", 8'h40, 8'h00);
        snap_chk(OFS_B2_LOW, 20'h0);
        frames(1'b0, 12);
        snap_chk(OFS_B2_MID, total);
        bus(1'b1, OFS_CTRL_STATUS, 8'h80);
        rd_chk("per_bit_sel", OFS_CTRL_STATUS, 8'h80);
        frames(1'b1, 12);
        snap_chk(OFS_MASTER, total);
        bus(1'b0, OFS_IRQ_EN_STATUS, 8'h00);
        bus(1'b1, OFS_IRQ_EN_STATUS, 8'hf0);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            case (k)
                0: rdi <= 1'b1;
                1: ais <= 1'b1;
                2: i_rlom_line_model.send_frame(5'd3);
                default: begin
                    fe <= 1'b1;
                    @(posedge ref_clk);
                    fe <= 1'b0;
                end
            endcase
            repeat (3) @(posedge ref_clk);
            chk("irq_low", 20'(irq_n), 20'h0);
            rd_chk("flags", OFS_IRQ_EN_STATUS, 8'hf0 | (8'h1 << k));
            repeat (2) @(posedge ref_clk);
            chk("irq_high", 20'(irq_n), 20'h1);
        end
        rd_chk("states", OFS_CTRL_STATUS, 8'h83);
        rdi <= 1'b0;
        ais <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_chk("rdi_change", OFS_IRQ_EN_STATUS, 8'hf1);
        rd_chk("states_off", OFS_CTRL_STATUS, 8'h80);
        for (int j = 0; j < 2; j++) begin
            loss_sig <= (j == 0);
            loss_frm <= (j == 1);
            repeat (3) @(posedge ref_clk);
            rd_chk("loss_state", OFS_CTRL_STATUS, 8'h82);
            rd_chk("loss_flag", OFS_IRQ_EN_STATUS, 8'hf2);
            loss_sig <= 1'b0;
            loss_frm <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        bus(1'b0, OFS_IRQ_EN_STATUS, 8'h00);
        bus(1'b1, OFS_IRQ_EN_STATUS, 8'h00);
        i_rlom_line_model.send_frame(5'd7);
        repeat (3) @(posedge ref_clk);
        chk("irq_masked", 20'(irq_n), 20'h1);
        rd_chk("masked_flag", OFS_IRQ_EN_STATUS, 8'h04);
        print_verdict();
    end
endmodule : tb_top
